// ---- hdl/pgu_global_ctrl.sv ----
// global update, counter sync and output enable stage for three generators
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module pgu_global_ctrl (
  input  wire logic                         clk_sys,     // system clock, 250 MHz
  input  wire logic                         rst,         // async reset, active high
  input  wire logic [pgu_pkg::ADDR_W-1:0]   regAddr,     // register byte address
  input  wire logic [pgu_pkg::DATA_W-1:0]   regWrData,   // register write data
  input  wire logic                         regWrEn,     // write strobe
  input  wire logic                         regRdEn,     // read strobe
  output logic      [pgu_pkg::DATA_W-1:0]   regRdData,   // read data, cycle after strobe
  input  wire logic [pgu_pkg::NUM_GEN-1:0]  cntZero,     // counter n at zero this cycle
  output logic      [pgu_pkg::NUM_GEN-1:0]  applyUpdate, // commit queued values, pulse
  output logic      [pgu_pkg::NUM_GEN-1:0]  cntReset,    // force counter n to zero, pulse
  output logic      [pgu_pkg::NUM_GEN-1:0]  updPending,  // update bits as stored
  input  wire logic [pgu_pkg::NUM_OUT-1:0]  genPwm,      // raw signals 0a,0b,1a,1b,2a,2b
  output logic      [pgu_pkg::NUM_OUT-1:0]  gatedPwm     // gated signals to polarity stage
);
  import pgu_pkg::*;

  // register match, shared by write and read decode
  function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    isReg = (a == off);
  endfunction

  logic [NUM_GEN-1:0] update_q;
  logic [NUM_GEN-1:0] update_d;
  logic [NUM_GEN-1:0] sync_q;
  logic [NUM_GEN-1:0] sync_d;
  logic [NUM_OUT-1:0] enReq_q;
  logic [NUM_OUT-1:0] enReq_d;
  logic               zeroMode_q;
  logic               zeroMode_d;
  logic [DATA_W-1:0]  rdData_q;
  logic [DATA_W-1:0]  rdData_d;
  logic               wrUpdate;
  logic               wrSync;
  logic               wrEnable;
  logic               chgAtZero;

  // write decode
  always_comb begin
    wrUpdate = 1'b0;
    wrSync   = 1'b0;
    wrEnable = 1'b0;
    if (regWrEn && isReg(regAddr, OFF_UPDATE_CTRL)) begin
      wrUpdate = 1'b1;
    end else if (regWrEn && isReg(regAddr, OFF_SYNC_RESET)) begin
      wrSync = 1'b1;
    end else if (regWrEn && isReg(regAddr, OFF_OUT_ENABLE)) begin
      wrEnable = 1'b1;
    end
  end

  // update bits: held until zero, a fresh write of one wins over the clear
  always_comb begin
    update_d = update_q & ~cntZero;
    if (wrUpdate) begin
      // ones set, zeros ignored
      update_d = update_d | regWrData[UPD_LSB +: NUM_GEN];
    end
  end

  // commit strobe in the very cycle the counter sits at zero
  assign applyUpdate = update_q & cntZero;
  assign updPending  = update_q;

  // counter reset bits: one cycle of reset, then self clear
  always_comb begin
    sync_d = '0;
    if (wrSync) begin
      // all bits of one write leave together
      sync_d = regWrData[SYNC_LSB +: NUM_GEN];
    end
  end

  // every selected counter sees the same pulse cycle
  assign cntReset = sync_q;

  // enable request and change-at-zero mode
  always_comb begin
    enReq_d    = enReq_q;
    zeroMode_d = zeroMode_q;
    if (wrEnable) begin
      enReq_d    = regWrData[EN_LSB +: NUM_OUT];
      zeroMode_d = regWrData[EN_ZERO_BIT];
    end
  end

  // the mode carried by a write governs that same write
  assign chgAtZero = wrEnable ? regWrData[EN_ZERO_BIT] : zeroMode_q;

  // read mux, registered so data stand the cycle after the strobe
  always_comb begin
    rdData_d = RST_RDATA;
    if (regRdEn && isReg(regAddr, OFF_UPDATE_CTRL)) begin
      rdData_d[UPD_LSB +: NUM_GEN] = update_q;
    end else if (regRdEn && isReg(regAddr, OFF_SYNC_RESET)) begin
      // zero read back means sync done
      rdData_d[SYNC_LSB +: NUM_GEN] = sync_q;
    end else if (regRdEn && isReg(regAddr, OFF_OUT_ENABLE)) begin
      rdData_d[EN_LSB +: NUM_OUT] = enReq_q;
      rdData_d[EN_ZERO_BIT]       = zeroMode_q;
    end
    // upper bits stay zero whatever is written
  end

  // register state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      update_q   <= RST_UPDATE;
      sync_q     <= RST_SYNC;
      enReq_q    <= RST_ENABLE;
      zeroMode_q <= RST_ZERO;
      rdData_q   <= RST_RDATA;
    end else begin
      update_q   <= update_d;
      sync_q     <= sync_d;
      enReq_q    <= enReq_d;
      zeroMode_q <= zeroMode_d;
      rdData_q   <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // one gate per generator, A in the even bit and B in the odd bit
  generate
    for (genvar g = 0; g < NUM_GEN; g++) begin : gGate
      pgu_out_gate uGate (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .zeroHit   (cntZero[g]),
        .chgAtZero (chgAtZero),
        .wrEn      (wrEnable),
        .wrBits    (regWrData[EN_LSB + 2*g +: 2]),
        .reqBits   (enReq_q[2*g +: 2]),
        .genPwm    (genPwm[2*g +: 2]),
        .gatedPwm  (gatedPwm[2*g +: 2])
      );
    end
  endgenerate

endmodule

// ---- hdl/pgu_out_gate.sv ----
// output enable gate for one generator's A and B signals
`timescale 1ns/1ps
module pgu_out_gate (
  input  wire logic       clk_sys,   // system clock
  input  wire logic       rst,       // async reset, active high
  input  wire logic       zeroHit,   // owning counter at zero
  input  wire logic       chgAtZero, // enable change waits for zero
  input  wire logic       wrEn,      // enable register written now
  input  wire logic [1:0] wrBits,    // written enable bits, b:a
  input  wire logic [1:0] reqBits,   // stored requested enables
  input  wire logic [1:0] genPwm,    // raw generator signals, b:a
  output logic      [1:0] gatedPwm   // gated signals to polarity
);
  import pgu_pkg::*;

  logic [1:0] actEn_q;
  logic [1:0] actEn_d;
  logic [1:0] gated_q;
  logic [1:0] gated_d;
  logic [1:0] pending;

  // choose when the requested enables become the active ones
  always_comb begin
    pending = wrEn ? wrBits : reqBits;
    actEn_d = actEn_q;
    if (chgAtZero) begin
      if (zeroHit) begin
        actEn_d = pending;
      end
    end else if (wrEn) begin
      actEn_d = wrBits;
    end
    // only masks, the generator is never told
    gated_d = genPwm & actEn_q;
  end

  // active enables and gated outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      actEn_q <= RST_ENABLE[1:0];
      gated_q <= 2'h0;
    end else begin
      actEn_q <= actEn_d;
      gated_q <= gated_d;
    end
  end

  assign gatedPwm = gated_q;

endmodule

// ---- hdl/pgu_pkg.sv ----
// constants, register map and field layout of the global update, sync and output gate stage
//
// Overview of operation
// - Setting update bit n makes generator n apply its queued load and compare values at its next counter zero.
// - An update bit clears itself once that generator has applied its queued values, and writing zero to it does nothing.
// - Writing one to counter-reset bit n forces counter n back to zero, and writing zero leaves it alone.
// - Counter-reset bits set by one write reset all their counters in the same clock cycle.
// - Hardware clears each counter-reset bit after the reset, so software reads zero as the sign that it is done.
// - Output enable bits 0 to 5 belong to generator 0 A, 0 B, 1 A, 1 B, 2 A, 2 B, and a set bit passes that signal on.
// - A clear output enable bit replaces its signal with zero before the polarity stage.
// - Disabling an output leaves its generator's counter, comparators and waveform running untouched.
// - With the change-at-zero bit 6 set, new enable values take effect only when the owning counter reaches zero.
// - All update, counter-reset and enable bits reset to zero, and reserved upper bits read only.
// - Gated signals are active high and go on to a per-output polarity stage ahead of the pins.
package pgu_pkg;

  // bus geometry
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int NUM_GEN = 3;
  localparam int NUM_OUT = 2 * NUM_GEN;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_UPDATE_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SYNC_RESET  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_OUT_ENABLE  = 12'h008;

  // field positions
  localparam int UPD_LSB      = 0;
  localparam int SYNC_LSB     = 0;
  localparam int EN_LSB       = 0;
  localparam int EN_ZERO_BIT  = 6;

  // values after reset
  localparam logic [NUM_GEN-1:0] RST_UPDATE = 3'h0;
  localparam logic [NUM_GEN-1:0] RST_SYNC   = 3'h0;
  localparam logic [NUM_OUT-1:0] RST_ENABLE = 6'h00;
  localparam logic               RST_ZERO   = 1'b0;
  localparam logic [DATA_W-1:0]  RST_RDATA  = 32'h0000_0000;

  // cycles from an enable write to the gated output with change-at-zero clear
  localparam int EN_LATENCY_CYC = 2;

endpackage

// ---- tb/pgu_gen_model.sv ----
// counter model of the three generators that feed the stage
`timescale 1ns/1ps
module pgu_gen_model (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst,      // async reset, active high
  input  wire logic [2:0] cntReset, // force counter n to zero
  output logic      [2:0] cntZero,  // counter n at zero
  output logic      [5:0] genPwm    // raw signals 0a,0b,1a,1b,2a,2b
);
  logic [3:0] cnt_q [3];
  // offset start phases, so only a sync reset lines them up
  always_ff @(posedge clk_sys or posedge rst) begin
    for (int g = 0; g < 3; g++) begin
      if (rst) cnt_q[g] <= 4'(g * 5);
      else if (cntReset[g]) cnt_q[g] <= 4'h0;
      else cnt_q[g] <= cnt_q[g] + 4'h1;
    end
  end
  // zero flag and a/b waveforms from each counter
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      cntZero[g] = (cnt_q[g] == 4'h0);
      genPwm[2*g] = cnt_q[g][1];
      genPwm[2*g+1] = cnt_q[g][2];
    end
  end
endmodule

// ---- tb/pgu_global_ctrl_properties.sv ----
// port-level assertions for the update, sync and output gate stage
`timescale 1ns/1ps
module pgu_global_ctrl_properties (
  input wire logic        clk_sys,     // system clock
  input wire logic        rst,         // async reset, active high
  input wire logic [11:0] regAddr,     // register address
  input wire logic [31:0] regWrData,   // write data
  input wire logic        regWrEn,     // write strobe
  input wire logic        regRdEn,     // read strobe
  input wire logic [31:0] regRdData,   // read data
  input wire logic [2:0]  cntZero,     // counter zero flags
  input wire logic [2:0]  applyUpdate, // commit pulses
  input wire logic [2:0]  cntReset,    // counter reset pulses
  input wire logic [2:0]  updPending,  // stored update bits
  input wire logic [5:0]  genPwm,      // raw signals
  input wire logic [5:0]  gatedPwm     // gated signals
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic updWr;
  logic syncWr;
  logic enWr;
  // decoded writes, kept as plain nets so they can be negated
  assign updWr = regWrEn && regAddr == 12'h000;
  assign syncWr = regWrEn && regAddr == 12'h004;
  assign enWr = regWrEn && regAddr == 12'h008;
  sequence syncEcho;
    cntReset == $past(regWrData[2:0]);
  endsequence
  upd_commit_a: assert property (applyUpdate == (updPending & cntZero))
    else $error("commit pulse not tied to zero");
  upd_set_a: assert property (updWr |=> updPending == ($past(updPending & ~cntZero)
    | $past(regWrData[2:0]))) else $error("update bits wrong after write");
  upd_hold_a: assert property (!updWr |=> updPending == $past(updPending & ~cntZero))
    else $error("update bits not held or cleared");
  sync_pulse_a: assert property (syncWr |=> syncEcho)
    else $error("counter reset pulse wrong");
  sync_clear_a: assert property (!syncWr |=> cntReset == 3'h0)
    else $error("counter reset without write");
  gate_zero_a: assert property (gatedPwm == (gatedPwm & $past(genPwm)))
    else $error("gated signal high without source");
  // immediate mode: new enables gate the output one edge after the write edge, sampled at the next edge
  gate_now_a: assert property (enWr && !regWrData[6] |=> ##1 gatedPwm ==
    ($past(genPwm) & $past(regWrData[5:0], 2))) else $error("enable not applied in time");
  rd_idle_a: assert property (!regRdEn |=> regRdData == 32'h0000_0000)
    else $error("read data outside read cycle");
  rd_upper_a: assert property (regRdEn |=> regRdData[31:7] == 25'h000_0000)
    else $error("reserved bits read nonzero");
endmodule
bind pgu_global_ctrl pgu_global_ctrl_properties i_pgu_global_ctrl_properties (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .cntZero(cntZero),
  .applyUpdate(applyUpdate), .cntReset(cntReset), .updPending(updPending),
  .genPwm(genPwm), .gatedPwm(gatedPwm));

// ---- tb/pgu_global_ctrl_tb.sv ----
// register-level tests of the update, sync and output gate stage
`timescale 1ns/1ps
module pgu_global_ctrl_tb;
  import pgu_pkg::*;
  logic clk_sys = 0, rst = 1, regWrEn = 0, regRdEn = 0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000, regRdData;
  logic [2:0] cntZero, applyUpdate, cntReset, updPending;
  logic [5:0] genPwm, gatedPwm, pwmPrev;
  logic [5:0] enTab [4] = '{6'h15, 6'h2A, 6'h3F, 6'h00};
  int mismatches = 0, n_compared = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  // previous raw value, since the gate is registered
  always @(posedge clk_sys) pwmPrev <= genPwm;
  pgu_global_ctrl i_pgu_global_ctrl (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .cntZero(cntZero), .applyUpdate(applyUpdate), .cntReset(cntReset),
    .updPending(updPending), .genPwm(genPwm), .gatedPwm(gatedPwm));
  pgu_gen_model i_pgu_gen_model (.clk_sys(clk_sys), .rst(rst), .cntReset(cntReset),
    .cntZero(cntZero), .genPwm(genPwm));
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    regWrEn <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    regRdEn <= 1'b1; regAddr <= a;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // waits for a cycle with counter 0 at zero, bounded
  task automatic wz();
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (cntZero[0] === 1'b1) break;
    end
  endtask
  task automatic gchk(logic [5:0] en, int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 chk({26'h000_0000, gatedPwm}, {26'h000_0000, pwmPrev & en});
    end
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin mismatches++; end_sim(); end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) rd(12'(a), 32'h0000_0000);
    $display("test reset values done");
    wr(OFF_SYNC_RESET, 32'h0000_0007);
    wz();
    chk(cntZero, 3'h7);
    rd(OFF_SYNC_RESET, 32'h0000_0000);
    $display("test counter sync done");
    wz();
    wr(OFF_UPDATE_CTRL, 32'h0000_0005);
    rd(OFF_UPDATE_CTRL, 32'h0000_0005);
    // a zero write must not cancel the pending bits
    wr(OFF_UPDATE_CTRL, 32'h0000_0000);
    rd(OFF_UPDATE_CTRL, 32'h0000_0005);
    wz();
    chk(applyUpdate, 3'h5);
    rd(OFF_UPDATE_CTRL, 32'h0000_0000);
    $display("test queued update done");
    for (int i = 0; i < 4; i++) begin
      wr(OFF_OUT_ENABLE, {26'h000_0000, enTab[i]});
      // first look one edge after the write edge, so a late enable shows up
      gchk(enTab[i], 8);
      rd(OFF_OUT_ENABLE, {26'h000_0000, enTab[i]});
    end
    $display("test output gate done");
    wz();
    wr(OFF_OUT_ENABLE, 32'h0000_007F);
    gchk(6'h00, 10);
    wz();
    @(posedge clk_sys);
    gchk(6'h3F, 8);
    $display("test change at zero done");
    end_sim();
  end
endmodule
